/* asichk_pkg.sv */
// Package for the alternate-space access checker: identifiers and types
package asichk_pkg;

  // ----------------------------------------------------------------
  // Space identifiers; the checker decodes all but 0x10, 0x11, 0x16 and 0x17
  // ----------------------------------------------------------------
  localparam logic [7:0] USER_PRIMARY_ID = 8'h10;
  localparam logic [7:0] USER_SECONDARY_ID = 8'h11;
  localparam logic [7:0] USER_PRI_BLOCK_ID = 8'h16;
  localparam logic [7:0] USER_SEC_BLOCK_ID = 8'h17;
  localparam logic [7:0] USER_PRIMARY_LE_ID = 8'h18;
  localparam logic [7:0] USER_SECONDARY_LE_ID = 8'h19;
  localparam logic [7:0] USER_PRI_BLOCK_LE_ID = 8'h1E;
  localparam logic [7:0] USER_SEC_BLOCK_LE_ID = 8'h1F;
  localparam logic [7:0] REAL_SPACE_ID = 8'h14;
  localparam logic [7:0] REAL_IO_SPACE_ID = 8'h15;
  localparam logic [7:0] REAL_SPACE_LE_ID = 8'h1C;
  localparam logic [7:0] REAL_IO_SPACE_LE_ID = 8'h1D;
  localparam logic [7:0] USER_PRI_PAIR_LOAD_ID = 8'h22;
  localparam logic [7:0] USER_SEC_PAIR_LOAD_ID = 8'h23;
  localparam logic [7:0] NUCLEUS_PAIR_LOAD_ID = 8'h27;
  localparam logic [7:0] USER_PRI_PAIR_LOAD_LE_ID = 8'h2A;
  localparam logic [7:0] USER_SEC_PAIR_LOAD_LE_ID = 8'h2B;
  localparam logic [7:0] NUCLEUS_PAIR_LOAD_LE_ID = 8'h2F;

  // ----------------------------------------------------------------
  // Alignment and widths
  // ----------------------------------------------------------------
  localparam int PAIR_ALIGN_BITS = 4;  // 16-byte alignment
  localparam int VA_W = 64;

  // ----------------------------------------------------------------
  // Instruction kinds presented by the load/store pipeline
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ASICHK_OP_LOAD = 4'h0,
    ASICHK_OP_STORE = 4'h1,
    ASICHK_OP_CMP_SWAP_WORD_ALT = 4'h2,
    ASICHK_OP_CMP_SWAP_DWORD_ALT = 4'h3,
    ASICHK_OP_LOAD_STORE_UBYTE_ALT = 4'h4,
    ASICHK_OP_SWAP_ALT = 4'h5,
    ASICHK_OP_PREFETCH_ALT = 4'h6,
    ASICHK_OP_PAIRED_DWORD_LOAD_ALT = 4'h7
  } asichk_op_t;

  // Context selection
  typedef enum logic [1:0] {
    ASICHK_CTX_PRIMARY = 2'h0,
    ASICHK_CTX_SECONDARY = 2'h1,
    ASICHK_CTX_NUCLEUS = 2'h2,
    ASICHK_CTX_NONE = 2'h3
  } asichk_ctx_t;

  // Space class of a decoded identifier
  typedef enum logic [2:0] {
    ASICHK_CLS_NONE = 3'h0,
    ASICHK_CLS_USER = 3'h1,
    ASICHK_CLS_REAL = 3'h2,
    ASICHK_CLS_REAL_IO = 3'h3,
    ASICHK_CLS_PAIR = 3'h4
  } asichk_cls_t;

  // Handshake states, one-hot
  typedef enum logic [1:0] {
    ASICHK_ST_IDLE = 2'b01,
    ASICHK_ST_RESULT = 2'b10
  } asichk_state_t;

endpackage

/* asichk_decode.sv */
// Identifier decoder: space class, context and byte-order inversion
`timescale 1ns/1ns
module asichk_decode (
  input wire logic [7:0] asi_i,                 // Space identifier
  output asichk_pkg::asichk_cls_t cls_o,        // Space class
  output asichk_pkg::asichk_ctx_t ctx_o,        // Context selection
  output logic le_variant_o                     // Opposite byte order variant
);

  // ----------------------------------------------------------------
  // Table decode
  // ----------------------------------------------------------------
  always_comb begin
    cls_o = asichk_pkg::ASICHK_CLS_NONE;
    ctx_o = asichk_pkg::ASICHK_CTX_NONE;
    le_variant_o = 1'b0;
    case (asi_i)
      asichk_pkg::USER_PRIMARY_LE_ID,
      asichk_pkg::USER_PRI_BLOCK_LE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_USER;
        ctx_o = asichk_pkg::ASICHK_CTX_PRIMARY;
        le_variant_o = 1'b1;
      end
      asichk_pkg::USER_SECONDARY_LE_ID,
      asichk_pkg::USER_SEC_BLOCK_LE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_USER;
        ctx_o = asichk_pkg::ASICHK_CTX_SECONDARY;
        le_variant_o = 1'b1;
      end
      asichk_pkg::REAL_SPACE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_REAL;
      end
      asichk_pkg::REAL_SPACE_LE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_REAL;
        le_variant_o = 1'b1;
      end
      asichk_pkg::REAL_IO_SPACE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_REAL_IO;
      end
      asichk_pkg::REAL_IO_SPACE_LE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_REAL_IO;
        le_variant_o = 1'b1;
      end
      asichk_pkg::USER_PRI_PAIR_LOAD_ID,
      asichk_pkg::USER_PRI_PAIR_LOAD_LE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_PAIR;
        ctx_o = asichk_pkg::ASICHK_CTX_PRIMARY;
        le_variant_o = asi_i[3];
      end
      asichk_pkg::USER_SEC_PAIR_LOAD_ID,
      asichk_pkg::USER_SEC_PAIR_LOAD_LE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_PAIR;
        ctx_o = asichk_pkg::ASICHK_CTX_SECONDARY;
        le_variant_o = asi_i[3];
      end
      asichk_pkg::NUCLEUS_PAIR_LOAD_ID,
      asichk_pkg::NUCLEUS_PAIR_LOAD_LE_ID: begin
        cls_o = asichk_pkg::ASICHK_CLS_PAIR;
        ctx_o = asichk_pkg::ASICHK_CTX_NUCLEUS;
        le_variant_o = asi_i[3];
      end
      default: begin
        cls_o = asichk_pkg::ASICHK_CLS_NONE;
      end
    endcase
  end

endmodule

/* asichk_fault.sv */
// Fault classifier: privilege trap, access fault and misalignment
`timescale 1ns/1ns
module asichk_fault (
  input asichk_pkg::asichk_cls_t cls_i,         // Space class
  input asichk_pkg::asichk_op_t op_i,           // Instruction kind
  input wire logic user_mode_i,                 // Nonprivileged mode
  input wire logic page_priv_only_bit_i,        // Page privileged bit
  input wire logic [3:0] addr_low_i,            // Low address bits
  output logic priv_trap_o,                     // Privileged action trap
  output logic access_fault_o,                  // Access fault
  output logic priv_violation_o,                // Access fault cause
  output logic misalign_o                       // Misalignment trap
);

  logic atomic_or_pf;
  logic atomic_op;

  // ----------------------------------------------------------------
  // Instruction kind groups
  // ----------------------------------------------------------------
  assign atomic_op = (op_i == asichk_pkg::ASICHK_OP_CMP_SWAP_WORD_ALT) ||
                     (op_i == asichk_pkg::ASICHK_OP_CMP_SWAP_DWORD_ALT) ||
                     (op_i == asichk_pkg::ASICHK_OP_LOAD_STORE_UBYTE_ALT) ||
                     (op_i == asichk_pkg::ASICHK_OP_SWAP_ALT);
  assign atomic_or_pf = atomic_op ||
                        (op_i == asichk_pkg::ASICHK_OP_PREFETCH_ALT);

  // Priority: privilege trap, then access fault, then alignment
  always_comb begin
    priv_trap_o = 1'b0;
    access_fault_o = 1'b0;
    priv_violation_o = 1'b0;
    misalign_o = 1'b0;
    case (cls_i)
      asichk_pkg::ASICHK_CLS_USER: begin
        if (user_mode_i) begin
          priv_trap_o = 1'b1;
        end else if (page_priv_only_bit_i) begin
          access_fault_o = 1'b1;
          priv_violation_o = 1'b1;
        end
      end
      asichk_pkg::ASICHK_CLS_REAL: begin
        priv_trap_o = user_mode_i;
      end
      asichk_pkg::ASICHK_CLS_REAL_IO: begin
        if (user_mode_i) begin
          priv_trap_o = 1'b1;
        end else if (atomic_or_pf) begin
          access_fault_o = 1'b1;
        end
      end
      asichk_pkg::ASICHK_CLS_PAIR: begin
        if (op_i != asichk_pkg::ASICHK_OP_PAIRED_DWORD_LOAD_ALT) begin
          access_fault_o = 1'b1;
        end else if (addr_low_i != 4'h0) begin
          misalign_o = 1'b1;
        end
      end
      default: begin
        priv_trap_o = 1'b0;
      end
    endcase
  end

endmodule

/* asichk_top.sv */
// Alternate-space access checker: qualifies one access per request
//
// What this block does
// - Spaces 0x18/0x19/0x1E/0x1F act as 0x10/0x11/0x16/0x17, order reversed.
// - An as-if-user LE access in nonprivileged mode gets the privilege trap.
// - Privileged: a privileged-only page gives a privilege-violation fault.
// - A permitted as-if-user LE access is little-endian unless inverted.
// - User LE spaces are virtual, primary 0x18/0x1E, secondary 0x19/0x1F.
// - Real space 0x14 in nonprivileged mode gets the privilege trap, any op.
// - Real spaces pass VA through, no context, big-endian unless inverted.
// - Every 0x14/0x1C access is cacheable, even with data translation off; real-I/O is not.
// - Real-I/O 0x15 skips the external cache and is a side-effect access.
// - Real-I/O space from nonprivileged mode raises the privilege trap.
// - Real-I/O compare-swap, byte load-store, swap, prefetch: access fault.
// - Spaces 0x1C and 0x1D act as 0x14 and 0x15 with reversed byte order.
// - Twin spaces serve paired loads, primary, secondary or nucleus context.
// - 0x22/0x23/0x27 big-endian unless inverted, 0x2A/0x2B/0x2F reversed.
// - A twin-space paired load off a 16-byte boundary raises misalignment.
// - Other ops on a twin space get the access fault, never misalignment.
`timescale 1ns/1ns
module asichk_top (
  input wire logic clk_i,                       // Core clock
  input wire logic rstn_i,                      // Synchronous reset, low
  input wire logic req_valid_i,                 // Access request strobe
  input wire logic [7:0] asi_i,                 // Space identifier
  input asichk_pkg::asichk_op_t op_i,           // Instruction kind
  input wire logic [63:0] va_i,                 // Virtual address
  input wire logic user_mode_i,                 // Nonprivileged mode
  input wire logic translation_on_i,            // Data translation enabled
  input wire logic page_priv_only_bit_i,        // Page privileged bit
  input wire logic page_invert_endian_bit_i,    // Page invert-endian bit
  input wire logic page_side_effect_bit_i,      // Page side-effect bit
  input wire logic page_cacheable_i,            // Page cacheable attribute
  output logic rsp_valid_o,                     // Result strobe
  output logic handled_o,                       // Identifier is ours
  output logic perform_o,                       // Access may proceed
  output logic priv_trap_o,                     // Privileged action trap
  output logic access_fault_o,                  // Access fault
  output logic priv_violation_o,                // Fault cause: privilege
  output logic misalign_o,                      // Misalignment trap
  output logic little_endian_o,                 // Byte order of access
  output logic translate_o,                     // Address goes through unit
  output asichk_pkg::asichk_ctx_t ctx_o,        // Context selection
  output logic [63:0] addr_o,                   // Address for translation
  output logic cacheable_o,                     // Access is cacheable
  output logic bypass_ext_cache_o,              // Skip external cache
  output logic side_effect_o,                   // Treat as side effect
  output logic busy_o                           // Result pending
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    asichk_pkg::asichk_state_t state;
    logic rsp_valid;
    logic handled;
    logic perform;
    logic priv_trap;
    logic access_fault;
    logic priv_violation;
    logic misalign;
    logic little_endian;
    logic translate;
    asichk_pkg::asichk_ctx_t ctx;
    logic [63:0] addr;
    logic cacheable;
    logic bypass;
    logic side_effect;
  } asichk_reg_t;

  asichk_reg_t st_q;
  asichk_reg_t st_d;

  asichk_pkg::asichk_cls_t cls;
  asichk_pkg::asichk_ctx_t dec_ctx;
  logic le_variant;
  logic f_priv_trap;
  logic f_access_fault;
  logic f_priv_violation;
  logic f_misalign;
  logic any_fault;

  // ----------------------------------------------------------------
  // Decode and fault classification
  // ----------------------------------------------------------------
  asichk_decode u_decode (
    .asi_i(asi_i),
    .cls_o(cls),
    .ctx_o(dec_ctx),
    .le_variant_o(le_variant)
  );

  asichk_fault u_fault (
    .cls_i(cls),
    .op_i(op_i),
    .user_mode_i(user_mode_i),
    .page_priv_only_bit_i(page_priv_only_bit_i),
    .addr_low_i(va_i[asichk_pkg::PAIR_ALIGN_BITS-1:0]),
    .priv_trap_o(f_priv_trap),
    .access_fault_o(f_access_fault),
    .priv_violation_o(f_priv_violation),
    .misalign_o(f_misalign)
  );

  assign any_fault = f_priv_trap | f_access_fault | f_misalign;

  // ----------------------------------------------------------------
  // Next-state logic: one result per request, one cycle later
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rsp_valid = 1'b0;
    case (st_q.state)
      asichk_pkg::ASICHK_ST_IDLE,
      asichk_pkg::ASICHK_ST_RESULT: begin
        if (req_valid_i) begin
          st_d.state = asichk_pkg::ASICHK_ST_RESULT;
          st_d.rsp_valid = 1'b1;
          st_d.handled = (cls != asichk_pkg::ASICHK_CLS_NONE);
          st_d.priv_trap = f_priv_trap;
          st_d.access_fault = f_access_fault;
          st_d.priv_violation = f_priv_violation;
          st_d.misalign = f_misalign;
          st_d.perform = st_d.handled && !any_fault;
          // Byte order: user spaces flip the big-endian default
          if (cls == asichk_pkg::ASICHK_CLS_USER) begin
            st_d.little_endian = !page_invert_endian_bit_i;
          end else begin
            st_d.little_endian = page_invert_endian_bit_i ^
                                 le_variant;
          end
          st_d.ctx = dec_ctx;
          st_d.translate = (cls == asichk_pkg::ASICHK_CLS_USER) ||
                           (cls == asichk_pkg::ASICHK_CLS_PAIR);
          st_d.addr = va_i;
          st_d.cacheable = page_cacheable_i;
          st_d.bypass = 1'b0;
          st_d.side_effect = page_side_effect_bit_i;
          if (cls == asichk_pkg::ASICHK_CLS_REAL) begin
            st_d.ctx = asichk_pkg::ASICHK_CTX_NONE;
            st_d.cacheable = 1'b1;
          end else if (cls == asichk_pkg::ASICHK_CLS_REAL_IO) begin
            st_d.ctx = asichk_pkg::ASICHK_CTX_NONE;
            st_d.cacheable = 1'b0;
            st_d.bypass = 1'b1;
            st_d.side_effect = 1'b1;
          end else if (cls == asichk_pkg::ASICHK_CLS_NONE) begin
            // Foreign spaces follow the data translation enable
            st_d.translate = translation_on_i;
          end
        end else begin
          st_d.state = asichk_pkg::ASICHK_ST_IDLE;
        end
      end
      default: begin
        st_d.state = asichk_pkg::ASICHK_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q <= '{state: asichk_pkg::ASICHK_ST_IDLE,
                ctx: asichk_pkg::ASICHK_CTX_NONE,
                addr: 64'h0,
                default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from the state record
  // ----------------------------------------------------------------
  assign rsp_valid_o = st_q.rsp_valid;
  assign handled_o = st_q.handled;
  assign perform_o = st_q.perform;
  assign priv_trap_o = st_q.priv_trap;
  assign access_fault_o = st_q.access_fault;
  assign priv_violation_o = st_q.priv_violation;
  assign misalign_o = st_q.misalign;
  assign little_endian_o = st_q.little_endian;
  assign translate_o = st_q.translate;
  assign ctx_o = st_q.ctx;
  assign addr_o = st_q.addr;
  assign cacheable_o = st_q.cacheable;
  assign bypass_ext_cache_o = st_q.bypass;
  assign side_effect_o = st_q.side_effect;
  assign busy_o = (st_q.state == asichk_pkg::ASICHK_ST_RESULT);

endmodule

/* asichk_props.sv */
// Checker: port-level properties of the access checker
`timescale 1ns/1ns
module asichk_props (
  input wire logic clk_i,                   // Clock
  input wire logic rstn_i,                  // Reset, low
  input wire logic req_valid_i,             // Request
  input wire logic [7:0] asi_i,             // Identifier
  input asichk_pkg::asichk_op_t op_i,       // Kind
  input wire logic [63:0] va_i,             // Address
  input wire logic user_mode_i,             // Nonprivileged
  input wire logic page_priv_only_bit_i,    // Page privileged
  input wire logic page_invert_endian_bit_i, // Page invert
  input wire logic rsp_valid_o,             // Result strobe
  input wire logic perform_o,               // Proceeds
  input wire logic priv_trap_o,             // Trap
  input wire logic access_fault_o,          // Fault
  input wire logic priv_violation_o,        // Cause
  input wire logic misalign_o,              // Misaligned
  input wire logic little_endian_o,         // Order
  input wire logic translate_o,             // Translated
  input asichk_pkg::asichk_ctx_t ctx_o,     // Context
  input wire logic [63:0] addr_o,           // Address out
  input wire logic cacheable_o,             // Cacheable
  input wire logic bypass_ext_cache_o,      // Bypass
  input wire logic side_effect_o            // Side effect
);
  // ----------------------------------------------------------------
  // Request classes
  // ----------------------------------------------------------------
  logic ule, rl, io, pr, ldst, atom, pld, flip, lo0, lo2;
  assign ule = req_valid_i && (asi_i inside {8'h18, 8'h19, 8'h1E, 8'h1F});
  assign rl = req_valid_i && (asi_i inside {8'h14, 8'h15, 8'h1C, 8'h1D});
  assign io = rl && asi_i[0];
  assign pr = req_valid_i &&
    (asi_i inside {8'h22, 8'h23, 8'h27, 8'h2A, 8'h2B, 8'h2F});
  assign ldst = op_i inside {asichk_pkg::ASICHK_OP_LOAD,
    asichk_pkg::ASICHK_OP_STORE};
  assign pld = op_i == asichk_pkg::ASICHK_OP_PAIRED_DWORD_LOAD_ALT;
  assign atom = !ldst && !pld;
  assign flip = asi_i[3];
  assign lo0 = asi_i[0];
  assign lo2 = asi_i[2];

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_rsp_one_edge: assert property (rsp_valid_o == $past(req_valid_i))
    else $error("result strobe not one edge after request");
  a_user_le_trap: assert property (
    ule && ldst && user_mode_i |=> priv_trap_o && !perform_o)
    else $error("user space from user mode not trapped");
  a_user_le_fault: assert property (
    ule && ldst && !user_mode_i && page_priv_only_bit_i |=>
    access_fault_o && priv_violation_o && !perform_o)
    else $error("privileged page not faulted");
  a_user_le_access: assert property (
    ule && ldst && !user_mode_i && !page_priv_only_bit_i |=>
    perform_o && translate_o &&
    little_endian_o != $past(page_invert_endian_bit_i) &&
    ctx_o == ($past(lo0) ? asichk_pkg::ASICHK_CTX_SECONDARY :
    asichk_pkg::ASICHK_CTX_PRIMARY))
    else $error("user space access wrong");
  a_real_user_trap: assert property (
    rl && user_mode_i |=> priv_trap_o && !perform_o)
    else $error("real space from user mode not trapped");
  a_real_pass_through: assert property (
    rl && !user_mode_i && !(io && atom) |=> perform_o && !translate_o &&
    addr_o == $past(va_i) && ctx_o == asichk_pkg::ASICHK_CTX_NONE &&
    little_endian_o == ($past(page_invert_endian_bit_i) ^ $past(flip)))
    else $error("real space access wrong");
  a_real_cacheable: assert property (
    rl && !io && !user_mode_i |=> cacheable_o)
    else $error("real space not cacheable");
  a_io_attrs: assert property (
    io && !atom && !user_mode_i |=> bypass_ext_cache_o && side_effect_o)
    else $error("real io attributes wrong");
  a_io_atomic_fault: assert property (
    io && atom && !user_mode_i |=> access_fault_o && !perform_o)
    else $error("real io atomic not faulted");
  a_pair_misalign: assert property (
    pr && pld && va_i[3:0] != 4'h0 |=> misalign_o && !perform_o)
    else $error("pair load misalignment missed");
  a_pair_other_op: assert property (
    pr && !pld |=> access_fault_o && !misalign_o && !perform_o)
    else $error("pair space other kind not faulted");
  a_pair_access: assert property (
    pr && pld && va_i[3:0] == 4'h0 |=> perform_o && translate_o &&
    little_endian_o == ($past(page_invert_endian_bit_i) ^ $past(flip)) &&
    ctx_o == ($past(lo2) ? asichk_pkg::ASICHK_CTX_NUCLEUS :
    $past(lo0) ? asichk_pkg::ASICHK_CTX_SECONDARY :
    asichk_pkg::ASICHK_CTX_PRIMARY))
    else $error("pair load access wrong");
  c_user_ok: cover property (ule && !user_mode_i ##1 perform_o);
  c_pair_mis: cover property (pr ##1 misalign_o);
  c_io_trap: cover property (io ##1 priv_trap_o);
endmodule

bind asichk_top asichk_props asichk_props_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
  .asi_i(asi_i), .op_i(op_i), .va_i(va_i), .user_mode_i(user_mode_i),
  .page_priv_only_bit_i(page_priv_only_bit_i),
  .page_invert_endian_bit_i(page_invert_endian_bit_i),
  .rsp_valid_o(rsp_valid_o), .perform_o(perform_o),
  .priv_trap_o(priv_trap_o), .access_fault_o(access_fault_o),
  .priv_violation_o(priv_violation_o), .misalign_o(misalign_o),
  .little_endian_o(little_endian_o), .translate_o(translate_o),
  .ctx_o(ctx_o), .addr_o(addr_o), .cacheable_o(cacheable_o),
  .bypass_ext_cache_o(bypass_ext_cache_o), .side_effect_o(side_effect_o)
);

/* asichk_page_model.sv */
// Page entry model: attributes of the page an address falls in
`timescale 1ns/1ns
module asichk_page_model (
  input wire logic [63:0] va_i,  // Access address
  output logic priv_only_o,      // Privileged-only page
  output logic invert_endian_o,  // Invert-endian page
  output logic side_effect_o,    // Side-effect page
  output logic cacheable_o       // Cacheable page
);
  // Each test page carries its attributes in address bits 15:12
  assign {cacheable_o, side_effect_o, invert_endian_o, priv_only_o} =
    va_i[15:12];
endmodule

/* tb_asichk_top.sv */
// Testbench for the alternate-space access checker
`timescale 1ns/1ns
module tb_asichk_top;
  logic clk_i, rstn_i, req, user, ton, pp, pie, pse, pca;
  logic rsp, hnd, prf, trp, afl, pvl, mis, le, tr, ca, by, se, busy;
  logic [7:0] asi;
  logic [63:0] va, addr;
  logic [10:0] fl;
  asichk_pkg::asichk_op_t op;
  asichk_pkg::asichk_ctx_t ctx;
  int num_errors, samples_checked;

  // ----------------------------------------------------------------
  // Design, page model, clock
  // ----------------------------------------------------------------
  asichk_top asichk_top_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req), .asi_i(asi),
    .op_i(op), .va_i(va), .user_mode_i(user), .translation_on_i(ton),
    .page_priv_only_bit_i(pp), .page_invert_endian_bit_i(pie),
    .page_side_effect_bit_i(pse), .page_cacheable_i(pca),
    .rsp_valid_o(rsp), .handled_o(hnd), .perform_o(prf),
    .priv_trap_o(trp), .access_fault_o(afl), .priv_violation_o(pvl),
    .misalign_o(mis), .little_endian_o(le), .translate_o(tr),
    .ctx_o(ctx), .addr_o(addr), .cacheable_o(ca),
    .bypass_ext_cache_o(by), .side_effect_o(se), .busy_o(busy)
  );
  asichk_page_model asichk_page_model_inst (
    .va_i(va), .priv_only_o(pp), .invert_endian_o(pie),
    .side_effect_o(pse), .cacheable_o(pca)
  );
  assign fl = {hnd, prf, trp, afl, pvl, mis, le, tr, ca, by, se};
  // Core clock
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Page attributes {cache, side, invert, priv} and low address bits
  function automatic logic [63:0] pg(input logic [3:0] at,
                                     input logic [3:0] lo);
    return {48'h0123_4567_89AB, at, 8'h5A, lo};
  endfunction
  // One request, then one idle cycle; results hold meanwhile
  task automatic send(input logic [7:0] a, input logic [3:0] o,
                      input logic [63:0] v, input logic u);
    asi = a;
    op = asichk_pkg::asichk_op_t'(o);
    va = v;
    user = u;
    req = 1'h1;
    @(posedge clk_i);
    #2;
    req = 1'h0;
    chk(64'({rsp, busy}), 64'h3);
    @(posedge clk_i);
    #2;
    chk(64'({rsp, busy}), 64'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_user_le();
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? 8'h18 + 8'(i) : 8'h1C + 8'(i);
      send(a, 4'h0, pg(4'h0, 4'h0), 1'h1);
      chk(64'(fl[10:5]), 64'h28);
      send(a, 4'h1, pg(4'h1, 4'h0), 1'h0);
      chk(64'(fl[10:5]), 64'h26);
      for (int j = 0; j < 2; j++) begin
        send(a, 4'(j), pg({2'h0, 1'(j), 1'h0}, 4'h0), 1'h0);
        chk(64'(fl[10:3]), j ? 64'hC1 : 64'hC3);
        chk(64'(ctx), 64'(i % 2));
      end
    end
    $display("user spaces done");
  endtask
  task automatic t_real();
    logic [7:0] a;
    logic [63:0] v;
    logic [10:0] e;
    ton = 1'h0;
    for (int i = 0; i < 4; i++) begin
      a = 8'h14 + 8'(i % 2) + (i > 1 ? 8'h08 : 8'h00);
      send(a, 4'(2 * i), pg(4'h0, 4'h0), 1'h1);
      chk(64'(fl[10:5]), 64'h28);
      for (int j = 0; j < 2; j++) begin
        v = pg({2'h0, 1'(j), 1'h0}, 4'h7);
        send(a, 4'h0, v, 1'h0);
        e = {6'h30, 1'(j) ^ (i > 1), 1'h0, i % 2 == 0, i % 2 == 1,
             i % 2 == 1};
        chk(64'(fl), 64'(e));
        chk(addr, v);
        chk(64'(ctx), 64'h3);
      end
    end
    ton = 1'h1;
    $display("real spaces done");
  endtask
  task automatic t_io_atomic();
    for (int i = 0; i < 2; i++) begin
      for (int k = 2; k < 7; k++) begin
        send(i ? 8'h1D : 8'h15, 4'(k), pg(4'h0, 4'h0), 1'h0);
        chk(64'(fl[10:5]), 64'h24);
      end
    end
    $display("real io atomics done");
  endtask
  task automatic t_pair();
    logic [7:0] ids [6] = '{8'h22, 8'h23, 8'h27, 8'h2A, 8'h2B, 8'h2F};
    logic [7:0] a;
    for (int i = 0; i < 6; i++) begin
      a = ids[i];
      for (int j = 0; j < 2; j++) begin
        send(a, 4'h7, pg({2'h0, 1'(j), 1'h0}, 4'h0), 1'h0);
        chk(64'(fl[10:3]), 64'({6'h30, 1'(j) ^ a[3], 1'h1}));
        chk(64'(ctx), a[2] ? 64'h2 : 64'(a[0]));
      end
      send(a, 4'h7, pg(4'h0, 4'h8), 1'h0);
      chk(64'(fl[10:5]), 64'h21);
      for (int k = 0; k < 7; k++) begin
        send(a, 4'(k), pg(4'h0, 4'h4), 1'h0);
        chk(64'(fl[10:5]), 64'h24);
      end
    end
    $display("pair loads done");
  endtask
  task automatic t_back_to_back();
    send(8'h80, 4'h0, pg(4'h0, 4'h0), 1'h0);
    chk(64'(fl[10:5]), 64'h00);
    chk(64'(tr), 64'h1);
    ton = 1'h0;
    send(8'h81, 4'h1, pg(4'h0, 4'h0), 1'h0);
    chk(64'(tr), 64'h0);
    ton = 1'h1;
    asi = 8'h14;
    va = pg(4'h0, 4'h1);
    req = 1'h1;
    @(posedge clk_i);
    #2;
    asi = 8'h1C;
    va = pg(4'h0, 4'h2);
    chk(64'({rsp, le}), 64'h2);
    @(posedge clk_i);
    #2;
    req = 1'h0;
    chk(64'({rsp, le}), 64'h3);
    chk(addr, pg(4'h0, 4'h2));
    @(posedge clk_i);
    #2;
    $display("back to back done");
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    samples_checked = 0;
    rstn_i = 1'h0;
    req = 1'h0;
    asi = 8'h00;
    op = asichk_pkg::ASICHK_OP_LOAD;
    va = 64'h0;
    user = 1'h0;
    ton = 1'h1;
    repeat (4) @(posedge clk_i);
    #2;
    rstn_i = 1'h1;
    chk(64'({fl, rsp, busy, ctx}), 64'h3);
    chk(addr, 64'h0);
    t_user_le();
    t_real();
    t_io_atomic();
    t_pair();
    t_back_to_back();
    close_out();
  end
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule
